// ==== include/door_override_pkg.sv ====
// Constants and types for the door override controller
package door_override_pkg;

  // Frame timebase at 50 MHz: one video frame of 1/30 s, as a parameter
  localparam int unsigned CLOCK_HZ          = 50000000;
  localparam int unsigned FRAME_RATE_HZ     = 30;
  localparam int unsigned FRAME_CYCLES      = CLOCK_HZ / FRAME_RATE_HZ;
  // Door loop repeats every ten frames
  localparam int unsigned POLL_FRAMES       = 10;
  // Reset value of the door drive (closed)
  localparam logic        DOOR_RESET_VALUE  = 1'b0;

  // How the door output was decided on the last poll
  typedef enum logic [1:0] {
    MODE_AUTO,
    MODE_OPEN,
    MODE_CLOSE
  } door_mode_t;

endpackage

// ==== src/door_override_controller.sv ====
// Door override controller: operator switch and script permission flag
//
// Overview of operation
// - Manual-open asserted drives door output on, ignoring the permission flag.
// - Manual-close alone drives door output off, ignoring the permission flag.
// - Neither manual input asserted means automatic mode.
// - In automatic mode the door output copies the permission flag.
// - Flag changes under manual request are accepted but do not move the door.
// - Inputs sampled and door output updated once every ten frames.
// - Opto input changes reach the logic in under one frame.
//
// Timing
// Frame counter wraps every FRAME_CYCLES_P clocks: one video frame.
// Poll counter wraps every POLL_FRAMES_P frames: the poll period.
// All inputs sampled at one edge, so no half-made decision.
// Door, mode and strobe registered together at that edge.
// Strobe high for the one cycle after the update edge.
//
// Inputs
// Switch contacts are asynchronous pins: three-stage synchronisers.
// A contact change is seen four to five clocks after it lands.
// Permission flag comes from same-clock logic: sampled directly.
// Flag may toggle freely; only its value at the poll edge counts.
//
// Outputs
// Door drive: one opens the doors, zero closes them.
// Mode: which branch decided the last update.
// Strobe: marks the cycle after each update.
//
// Decision order
// Open contact checked first, so a shorted switch opens the door.
// Close contact checked second; flag ignored under either contact.
// Automatic mode has no pin of its own: both contacts released.
//
// Reset
// Door held closed and mode automatic while reset is low.
// Counters restart at zero; first update one full period later.
// Synchronisers clear to released, so no false contact after reset.
//
// Hazards
// Door only moves on a poll edge, so contact bounce shorter than
// the agreement window never reaches the door drive.
// Between polls the door holds its last decision, whatever the flag.
// A contact change just before a poll may wait one more period.
// Timing parameters below the checked minimum are refused.
`timescale 1ns/100ps
module door_override_controller
  import door_override_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES_P = FRAME_CYCLES,
  parameter int unsigned POLL_FRAMES_P  = POLL_FRAMES
)
(
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       manual_open_request_i,
  input  wire logic       manual_close_request_i,
  input  wire logic       script_door_permission_i,
  output logic            door_drive_out_o,
  output door_mode_t      door_mode_o,
  output logic            poll_strobe_o
);

  localparam int unsigned CYC_W = $clog2(FRAME_CYCLES_P + 1);
  localparam int unsigned FRM_W = $clog2(POLL_FRAMES_P + 1);

  // Refuse a frame too short for the synchroniser delay
  if (FRAME_CYCLES_P < 4)
  begin : g_bad_frame
    $error("door_override_controller: frame length too short");
  end

  // Refuse a poll period of no frames
  if (POLL_FRAMES_P < 1)
  begin : g_bad_poll
    $error("door_override_controller: poll period too short");
  end

  typedef struct packed {
    logic [CYC_W-1:0] cycle_cnt;
    logic [FRM_W-1:0] frame_cnt;
    logic             door;
    door_mode_t       mode;
    logic             strobe;
  } ctrl_state_t;

  ctrl_state_t state_q;
  ctrl_state_t state_d;
  logic        open_req;
  logic        close_req;
  logic        frame_end;
  logic        poll_now;
  logic [1:0]  pin_raw;
  logic [1:0]  req_lvl;

  // Advance the frame and poll counters; wrap each at its limit
  function automatic ctrl_state_t count_step(
    input ctrl_state_t cur,
    input logic        at_frame_end,
    input logic        at_poll
  );
    ctrl_state_t nxt;
    nxt = cur;
    if (at_frame_end)
    begin
      nxt.cycle_cnt = '0;
      if (at_poll)
      begin
        nxt.frame_cnt = '0;
      end
      else
      begin
        nxt.frame_cnt = cur.frame_cnt + FRM_W'(1);
      end
    end
    else
    begin
      nxt.cycle_cnt = cur.cycle_cnt + CYC_W'(1);
    end
    return nxt;
  endfunction

  // Poll decision: open first, then close, then the permission flag
  function automatic ctrl_state_t apply_poll(
    input ctrl_state_t cur,
    input logic        open_in,
    input logic        close_in,
    input logic        flag_in
  );
    ctrl_state_t nxt;
    nxt        = cur;
    nxt.strobe = 1'b1;
    if (open_in)
    begin
      nxt.door = 1'b1;
      nxt.mode = MODE_OPEN;
    end
    else if (close_in)
    begin
      nxt.door = 1'b0;
      nxt.mode = MODE_CLOSE;
    end
    else
    begin
      nxt.door = flag_in;
      nxt.mode = MODE_AUTO;
    end
    return nxt;
  endfunction

  // Bit 0 open contact, bit 1 close contact
  assign pin_raw = {manual_close_request_i, manual_open_request_i};

  // Opto inputs settle in five cycles, far under a frame
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_sync
    input_sync u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .pin_i   (pin_raw[gi]),
      .level_o (req_lvl[gi])
    );
  end

  assign open_req  = req_lvl[0];
  assign close_req = req_lvl[1];

  // Frame and poll period tick
  assign frame_end = (state_q.cycle_cnt == CYC_W'(FRAME_CYCLES_P - 1));
  assign poll_now  = frame_end
                   && (state_q.frame_cnt == FRM_W'(POLL_FRAMES_P - 1));

  // Poll loop: evaluate open, then close, then the permission flag
  always_comb
  begin
    state_d        = count_step(state_q, frame_end, poll_now);
    state_d.strobe = 1'b0;
    if (poll_now)
    begin
      state_d = apply_poll(state_d, open_req, close_req,
                           script_door_permission_i);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q.cycle_cnt <= '0;
      state_q.frame_cnt <= '0;
      state_q.door      <= DOOR_RESET_VALUE;
      state_q.mode      <= MODE_AUTO;
      state_q.strobe    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign door_drive_out_o = state_q.door;
  assign door_mode_o      = state_q.mode;
  assign poll_strobe_o    = state_q.strobe;

endmodule

// ==== src/input_sync.sv ====
// Three-stage synchroniser for an opto-isolated input
`timescale 1ns/100ps
module input_sync
  import door_override_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  // Shift in; accept a change once stages two and three agree
  always_comb
  begin
    state_d       = state_q;
    state_d.s1    = pin_i;
    state_d.s2    = state_q.s1;
    state_d.s3    = state_q.s2;
    if (state_q.s2 == state_q.s3)
    begin
      state_d.level = state_q.s3;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign level_o = state_q.level;

endmodule

// ==== verif/door_properties.sv ====
// Door controller checker
`timescale 1ns/100ps
module door_properties
  import door_override_pkg::*;
#(
  parameter int unsigned PERIOD = 16
)
(
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       manual_open_request_i,
  input wire logic       manual_close_request_i,
  input wire logic       script_door_permission_i,
  input wire logic       door_drive_out_o,
  input wire logic       poll_strobe_o,
  input wire door_mode_t door_mode_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [6:0]  op_q, cl_q;
  logic [31:0] gap_q;
  // Clocks since reset or since the last strobe
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      gap_q <= '0;
    else if (poll_strobe_o)
      gap_q <= 32'h1;
    else
      gap_q <= gap_q + 32'h1;
  end
  // Pin history, covers the sync delay
  always_ff @(posedge clock_i)
  begin
    op_q <= {op_q[5:0], manual_open_request_i};
    cl_q <= {cl_q[5:0], manual_close_request_i};
  end
  sequence quiet; !poll_strobe_o [*8]; endsequence
  a_open_wins: assert property (poll_strobe_o && &op_q |->
    door_drive_out_o && door_mode_o == MODE_OPEN) else $error("open");
  a_close_forces: assert property (poll_strobe_o && !op_q && &cl_q
    |-> !door_drive_out_o && door_mode_o == MODE_CLOSE) else $error("close");
  a_auto_copy: assert property (poll_strobe_o && !op_q && !cl_q |->
    door_drive_out_o == $past(script_door_permission_i)) else $error("auto");
  a_poll_period: assert property (
    poll_strobe_o == (gap_q == 32'(PERIOD))) else $error("period");
  a_strobe_gap: assert property (poll_strobe_o |=> quiet)
    else $error("gap");
  a_door_holds: assert property (!poll_strobe_o |->
    $stable(door_drive_out_o)) else $error("door moved");
  a_mode_holds: assert property (!poll_strobe_o |->
    $stable(door_mode_o)) else $error("mode moved");
endmodule
bind door_override_controller door_properties
  #(.PERIOD(FRAME_CYCLES_P * POLL_FRAMES_P)) chk_inst (.*);

// ==== verif/switch_model.sv ====
// Operator switch model driving the two manual request pins
`timescale 1ns/100ps
module switch_model
(
  input  wire logic [1:0] pos_i,
  output logic            open_o,
  output logic            close_o
);
  // Bit 0 open contact, bit 1 close contact
  assign open_o  = pos_i[0];
  assign close_o = pos_i[1];
endmodule

// ==== verif/tb.sv ====
// Door controller testbench
`timescale 1ns/100ps
module tb
  import door_override_pkg::*;
;
  logic clock_i = 0, rst_n_i = 0, perm = 0, op, cl, door, strobe;
  logic [1:0] pos = 0;
  door_mode_t mode;
  int n_mismatch = 0, tests_run = 0;
  always #10 clock_i = ~clock_i;
  switch_model sw_inst (.pos_i(pos), .open_o(op), .close_o(cl));
  door_override_controller #(.FRAME_CYCLES_P(8), .POLL_FRAMES_P(2))
    door_override_controller_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .manual_open_request_i(op), .manual_close_request_i(cl),
    .script_door_permission_i(perm), .door_drive_out_o(door),
    .door_mode_o(mode), .poll_strobe_o(strobe));
  task check(logic [2:0] seen, logic [2:0] exp, string what);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Step to the next update strobe, bounded
  task poll;
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clock_i);
      #1;
      if (strobe === 1'b1) break;
    end
    if (i == 40) n_mismatch++;
  endtask
  task step(logic [1:0] p, logic f, logic d, door_mode_t m, string s);
    pos = p;
    perm = f;
    poll;
    poll;
    check({door, mode}, {d, m}, s);
    @(posedge clock_i);
    #1;
    check(strobe, 0, "strobe drop");
    $display("test %s done", s);
  endtask
  task t_flag_hold;
    step(0, 1, 1, MODE_AUTO, "auto on");
    perm = 0;
    repeat (5) @(posedge clock_i);
    check(door, 1, "hold");
    poll;
    check(door, 0, "auto off");
    $display("test flag hold done");
  endtask
  task close_out;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    close_out;
  end
  initial
  begin
    repeat (6) @(posedge clock_i);
    #1 rst_n_i = 1;
    check({door, mode}, {1'b0, MODE_AUTO}, "reset");
    step(1, 0, 1, MODE_OPEN, "open");
    step(2, 1, 0, MODE_CLOSE, "close");
    step(3, 0, 1, MODE_OPEN, "both");
    t_flag_hold;
    close_out;
  end
endmodule
